/* File: include/dcup_defines.svh */
`ifndef DCUP_DEFINES_SVH
`define DCUP_DEFINES_SVH
// ==========================================
// register byte offsets
`define DCUP_CTRL_OFS 12'h000
`define DCUP_STAT_OFS 12'h004
`define DCUP_EVT_OFS 12'h008
// ==========================================
// control fields and reset value
`define DCUP_CTRL_FLT_LO 0
`define DCUP_CTRL_FLT_UP 1
`define DCUP_CTRL_LOOP 2
`define DCUP_CTRL_SOFT_RESET_REQUEST 3
`define DCUP_CTRL_RST 3'h0
// ==========================================
// status fields
`define DCUP_ST_SE_LO 0
`define DCUP_ST_SE_UP 1
`define DCUP_ST_LOCK_LO 2
`define DCUP_ST_LOCK_UP 3
`define DCUP_ST_MAN 4
`define DCUP_ST_PAR 5
// ==========================================
// timing and framing
`define DCUP_PCLK_HZ 20000000
`define DCUP_RATE_MAX_BPS 2000000
`define DCUP_CHAR_BITS 12
`define DCUP_PRE_PAT 10'h22a
`define DCUP_STP_PAT 10'h2a8
`endif

/* File: include/dcup_pkg.sv */
package dcup_pkg;
  // link rate codes: 2, 1 and 0.5 Mb/s
  typedef enum logic [1:0] {
    DCUP_R2M = 2'h0,
    DCUP_R1M = 2'h1,
    DCUP_R05M = 2'h2
  } dcup_rate_t;
  // character receiver states
  typedef enum logic [1:0] {
    DCUP_IDLE = 2'h1,
    DCUP_BITS = 2'h2
  } dcup_rxst_t;
  // one received character
  typedef struct packed {
    logic done;
    logic pre;
    logic stp;
    logic man;
    logic par;
    logic [3:0] nib;
  } dcup_evt_t;
  // receiver state seen by the port logic
  typedef struct packed {
    logic lock;
    logic se;
    dcup_rate_t rate;
    logic dat;
    logic act;
  } dcup_rxs_t;
endpackage

/* File: rtl/dcup_rx.sv */
`timescale 1ns/1ps
`include "dcup_defines.svh"

module dcup_rx
  import dcup_pkg::*;
(
  // clock, reset, soft restart
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  // line pins and internal loop source
  input wire logic pin_p,
  input wire logic pin_n,
  input wire logic loop_sel,
  input wire logic loop_p,
  input wire logic loop_n,
  // state and character events
  output dcup_rxs_t stat,
  output dcup_evt_t evt
);
  // ==========================================
  // helpers
  // bit period in pclk cycles for a rate code
  function automatic logic [7:0] bit_cyc(input dcup_rate_t r);
    bit_cyc = 8'(`DCUP_PCLK_HZ / (`DCUP_RATE_MAX_BPS >> r));
  endfunction
  // nearest supported rate to a measured bit time
  function automatic dcup_rate_t rate_of(input logic [7:0] m);
    logic [7:0] t0;
    logic [7:0] t1;
    t0 = bit_cyc(DCUP_R2M) + (bit_cyc(DCUP_R2M) >> 1);
    t1 = bit_cyc(DCUP_R1M) + (bit_cyc(DCUP_R1M) >> 1);
    rate_of = (m < t0) ? DCUP_R2M : (m < t1) ? DCUP_R1M : DCUP_R05M;
  endfunction
  // classify a finished frame, bit 0 is the start bit
  function automatic dcup_evt_t classify(input logic [11:0] f);
    dcup_evt_t e;
    e.done = 1'b1;
    e.pre = (f[9:0] == `DCUP_PRE_PAT);
    e.stp = (f[9:0] == `DCUP_STP_PAT);
    e.man = ~e.pre & ~e.stp & ((f[1] == f[2]) | (f[3] == f[4]) | (f[5] == f[6]) | (f[7] == f[8]));
    e.par = ~e.pre & ~e.stp & (^f);
    e.nib = {f[7], f[5], f[3], f[1]};
    classify = e;
  endfunction

  // ==========================================
  // input path
  logic [1:0] sp_q;
  logic [1:0] sn_q;
  logic nd_q;
  logic seen_q;
  logic dec_q;
  logic se_q;
  logic lock_q;
  dcup_rate_t rate_q;
  logic [7:0] meas_q;
  logic [7:0] act_q;
  logic [7:0] cnt_q;
  logic [3:0] idx_q;
  logic [10:0] sh_q;
  dcup_rxst_t st_q;
  dcup_evt_t evt_q;

  // pins pass two flops; loopback ignores the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_q <= 2'h0;
      sn_q <= 2'h0;
    end
    else
    begin
      sp_q <= {sp_q[0], pin_p};
      sn_q <= {sn_q[0], pin_n};
    end
  end

  wire p = loop_sel ? loop_p : sp_q[1];
  wire n = loop_sel ? loop_n : sn_q[1];
  wire dat = se_q ? ~n : p;
  wire [7:0] bc = bit_cyc(rate_q);
  wire n_rise = n & ~nd_q;
  wire n_fall = ~n & nd_q;
  wire start = (st_q == DCUP_IDLE) & lock_q & n_rise; // start bit raises the inverted line, idle low/low does not
  wire last = (st_q == DCUP_BITS) & (cnt_q == 8'h0) & (idx_q == 4'(`DCUP_CHAR_BITS - 1));

  // ==========================================
  // mode and rate detection on the first preamble
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nd_q <= 1'b0;
      seen_q <= 1'b0;
      dec_q <= 1'b0;
      se_q <= 1'b0;
      lock_q <= 1'b0;
      rate_q <= DCUP_R2M;
      meas_q <= 8'h0;
    end
    else if (restart)
    begin
      nd_q <= 1'b0;
      seen_q <= 1'b0;
      dec_q <= 1'b0;
      se_q <= 1'b0;
      lock_q <= 1'b0;
      rate_q <= DCUP_R2M;
      meas_q <= 8'h0;
    end
    else
    begin
      nd_q <= n;
      seen_q <= seen_q | p;
      if (n_rise & ~dec_q)
      begin
        dec_q <= 1'b1;
        se_q <= ~seen_q & ~p;
      end
      if (n_rise)
        meas_q <= 8'h1;
      else if (n & (meas_q != 8'hff))
        meas_q <= meas_q + 8'h1;
      if (n_fall & dec_q & ~lock_q)
      begin
        lock_q <= 1'b1;
        rate_q <= rate_of(meas_q);
      end
    end
  end

  // single-ended idle reads as one, so a two bit window bridges runs of ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_q <= 8'h0;
    else if (p | n)
      act_q <= {bc[6:0], 1'b0};
    else if (act_q != 8'h0)
      act_q <= act_q - 8'h1;
  end

  // ==========================================
  // twelve-bit character framing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= DCUP_IDLE;
      cnt_q <= 8'h0;
      idx_q <= 4'h0;
      sh_q <= 11'h0;
      evt_q <= '0;
    end
    else
    begin
      evt_q <= last ? classify({dat, sh_q}) : '0;
      case (st_q)
        DCUP_IDLE:
          if (start)
          begin
            st_q <= DCUP_BITS;
            cnt_q <= {1'b0, bc[7:1]};
            idx_q <= 4'h0;
          end
        DCUP_BITS:
          if (restart | last)
            st_q <= DCUP_IDLE;
          else if (cnt_q != 8'h0)
            cnt_q <= cnt_q - 8'h1;
          else
          begin
            cnt_q <= bc - 8'h1;
            sh_q[idx_q] <= dat;
            idx_q <= idx_q + 4'h1;
          end
        default:
          st_q <= DCUP_IDLE;
      endcase
    end
  end

  // differential: active only while a pin is high, so no zero is repeated into idle
  assign stat = {lock_q, se_q, rate_q, dat, (p | n) | (se_q & (act_q != 8'h0))};
  assign evt = evt_q;

  // a measured bit time under 15 cycles maps to the 2 Mb/s rate
  property p_rate_near;
    @(posedge pclk) disable iff (!presetn || restart)
    (n_fall && dec_q && !lock_q && meas_q < 8'd15) |=> (rate_q == DCUP_R2M && lock_q);
  endproperty
  a_rate_near: assert property (p_rate_near) else $error("rate not nearest");
endmodule

/* File: rtl/dcup_port.sv */
`timescale 1ns/1ps
`include "dcup_defines.svh"

module dcup_port
  import dcup_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lower port pins
  input wire logic lower_rx_true_input,
  input wire logic lower_rx_inverted_input,
  output logic lower_tx_true,
  output logic lower_tx_inv,
  output logic lower_tx_oe,
  // upper port pins
  input wire logic upper_rx_true_input,
  input wire logic upper_rx_inverted_input,
  output logic upper_tx_true,
  output logic upper_tx_inv,
  output logic upper_tx_oe
);
  // ==========================================
  // state
  logic [2:0] ctrl_q;
  logic restart_q;
  logic man_q;
  logic par_q;
  logic [31:0] prdata_q;
  logic [3:0] nib_q;
  logic [7:0] npre_q;
  logic [7:0] nstp_q;
  logic lo_p_q;
  logic lo_n_q;
  logic lo_oe_q;
  logic up_p_q;
  logic up_n_q;
  logic up_oe_q;
  dcup_rxs_t lo_s;
  dcup_rxs_t up_s;
  dcup_evt_t lo_e;
  dcup_evt_t up_e;

  // ==========================================
  // apb decode
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire hit_ctrl = (paddr == `DCUP_CTRL_OFS);
  wire hit_stat = (paddr == `DCUP_STAT_OFS);
  wire hit_evt = (paddr == `DCUP_EVT_OFS);
  wire hit = hit_ctrl | hit_stat | hit_evt;
  wire wr = acc & pwrite & hit;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_stat = wr & hit_stat;
  wire soft_reset_request_w = wr_ctrl & pwdata[`DCUP_CTRL_SOFT_RESET_REQUEST];
  wire clr_man = wr_stat & pwdata[`DCUP_ST_MAN];
  wire clr_par = wr_stat & pwdata[`DCUP_ST_PAR];

  // read words
  wire [31:0] stat_w = {22'h0, up_s.rate, lo_s.rate, par_q, man_q, up_s.lock, lo_s.lock, up_s.se, lo_s.se};
  wire [31:0] evt_w = {8'h0, nstp_q, npre_q, 4'h0, nib_q};
  wire [31:0] rd_w = hit_ctrl ? {29'h0, ctrl_q} :
                     hit_stat ? stat_w :
                     hit_evt ? evt_w : 32'h0;

  // zero wait states; unmapped access gets an error
  assign pready = acc;
  assign pslverr = acc & ~hit;
  assign prdata = prdata_q;

  // read data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (setup & ~pwrite)
      prdata_q <= rd_w;
  end

  // ==========================================
  // control register and soft reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `DCUP_CTRL_RST;
      restart_q <= 1'b0;
    end
    else
    begin
      restart_q <= soft_reset_request_w;
      if (soft_reset_request_w)
        ctrl_q <= `DCUP_CTRL_RST;
      else if (wr_ctrl)
        ctrl_q <= pwdata[2:0];
    end
  end

  // ==========================================
  // receivers
  // upper receiver reads its pins or the upper transmitter
  dcup_rx u_lo (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart_q),
    .pin_p(lower_rx_true_input),
    .pin_n(lower_rx_inverted_input),
    .loop_sel(1'b0),
    .loop_p(1'b0),
    .loop_n(1'b0),
    .stat(lo_s),
    .evt(lo_e)
  );

  dcup_rx u_up (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart_q),
    .pin_p(upper_rx_true_input),
    .pin_n(upper_rx_inverted_input),
    .loop_sel(ctrl_q[`DCUP_CTRL_LOOP]),
    .loop_p(up_p_q),
    .loop_n(up_n_q),
    .stat(up_s),
    .evt(up_e)
  );

  // ==========================================
  // sticky character errors, set wins over clear
  wire man_set = (lo_e.done & lo_e.man) | (up_e.done & up_e.man);
  wire par_set = (lo_e.done & lo_e.par) | (up_e.done & up_e.par);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      man_q <= 1'b0;
      par_q <= 1'b0;
    end
    else if (restart_q)
    begin
      man_q <= 1'b0;
      par_q <= 1'b0;
    end
    else
    begin
      man_q <= man_set | (man_q & ~clr_man);
      par_q <= par_set | (par_q & ~clr_par);
    end
  end

  // lower port character log: last nibble and framing counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nib_q <= 4'h0;
      npre_q <= 8'h0;
      nstp_q <= 8'h0;
    end
    else if (restart_q)
    begin
      nib_q <= 4'h0;
      npre_q <= 8'h0;
      nstp_q <= 8'h0;
    end
    else if (lo_e.done)
    begin
      if (lo_e.pre)
        npre_q <= npre_q + 8'h1;
      else if (lo_e.stp)
        nstp_q <= nstp_q + 8'h1;
      else
        nib_q <= lo_e.nib;
    end
  end

  // ==========================================
  // repeaters: after lock the bit stream passes through, driven as a differential pair,
  // so nothing is repeated before lock or while the receiver is not active
  wire up_fwd = lo_s.lock & lo_s.act;
  wire lo_fwd = up_s.lock & up_s.act;

  // upper transmitter repeats the lower receiver
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_p_q <= 1'b0;
      up_n_q <= 1'b0;
      up_oe_q <= 1'b1;
    end
    else
    begin
      up_p_q <= up_fwd & lo_s.dat;
      up_n_q <= up_fwd & ~lo_s.dat;
      up_oe_q <= up_fwd | ~ctrl_q[`DCUP_CTRL_FLT_UP];
    end
  end

  // lower transmitter repeats the upper receiver
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_p_q <= 1'b0;
      lo_n_q <= 1'b0;
      lo_oe_q <= 1'b1;
    end
    else
    begin
      lo_p_q <= lo_fwd & up_s.dat;
      lo_n_q <= lo_fwd & ~up_s.dat;
      lo_oe_q <= lo_fwd | ~ctrl_q[`DCUP_CTRL_FLT_LO];
    end
  end

  assign upper_tx_true = up_p_q;
  assign upper_tx_inv = up_n_q;
  assign upper_tx_oe = up_oe_q;
  assign lower_tx_true = lo_p_q;
  assign lower_tx_inv = lo_n_q;
  assign lower_tx_oe = lo_oe_q;

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_up_repeat;
    up_fwd |=> (upper_tx_true == $past(lo_s.dat)) && (upper_tx_inv != upper_tx_true);
  endproperty
  a_up_repeat: assert property (p_up_repeat) else $error("upper tx not repeating");

  property p_lo_repeat;
    lo_fwd |=> (lower_tx_true == $past(up_s.dat)) && lower_tx_oe;
  endproperty
  a_lo_repeat: assert property (p_lo_repeat) else $error("lower tx not repeating");

  property p_quiet_unlocked;
    !lo_s.lock |=> !upper_tx_true && !upper_tx_inv;
  endproperty
  a_quiet_unlocked: assert property (p_quiet_unlocked) else $error("upper tx before lock");

  property p_idle_low;
    (!up_fwd && !ctrl_q[`DCUP_CTRL_FLT_UP]) |=> upper_tx_oe && !upper_tx_true && !upper_tx_inv;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle upper tx not low");

  property p_idle_float;
    (!lo_fwd && ctrl_q[`DCUP_CTRL_FLT_LO]) |=> !lower_tx_oe;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("idle lower tx driven");

  property p_rate_hold;
    (lo_s.lock && !restart_q && !soft_reset_request_w) |=> lo_s.lock && $stable(lo_s.rate) && $stable(lo_s.se);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate or mode changed");

  property p_mode_read;
    (setup && !pwrite && hit_stat) |=> prdata[`DCUP_ST_SE_UP] == $past(up_s.se);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode flag misread");

  property p_man_sticky;
    (lo_e.done && lo_e.man && !restart_q) |=> man_q ##1 (man_q || $past(clr_man));
  endproperty
  a_man_sticky: assert property (p_man_sticky) else $error("encoding flag lost");

  property p_par_set;
    (up_e.done && up_e.par && !restart_q) |=> par_q;
  endproperty
  a_par_set: assert property (p_par_set) else $error("parity flag lost");

  property p_slverr;
    (acc && !hit) |-> pslverr && pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");

  property p_soft_reset_request;
    soft_reset_request_w |=> restart_q ##1 (!lo_s.lock && !up_s.lock && ctrl_q == `DCUP_CTRL_RST);
  endproperty
  a_soft_reset_request: assert property (p_soft_reset_request) else $error("soft reset incomplete");

  property p_lo_quiet;
    !up_s.lock |=> !lower_tx_true && !lower_tx_inv;
  endproperty
  a_lo_quiet: assert property (p_lo_quiet) else $error("lower tx before lock");

  property p_up_float;
    (!up_fwd && ctrl_q[`DCUP_CTRL_FLT_UP]) |=> !upper_tx_oe;
  endproperty
  a_up_float: assert property (p_up_float) else $error("idle upper tx driven");

  property p_pre_count;
    (lo_e.done && lo_e.pre && !restart_q) |=> npre_q == $past(npre_q) + 8'h1;
  endproperty
  a_pre_count: assert property (p_pre_count) else $error("preamble not counted");

  property p_stp_count;
    (lo_e.done && lo_e.stp && !restart_q) |=> nstp_q == $past(nstp_q) + 8'h1;
  endproperty
  a_stp_count: assert property (p_stp_count) else $error("stop character not counted");

  c_lo_lock: cover property (!lo_s.lock ##1 lo_s.lock);
  c_both_err: cover property (par_q && man_q);
  c_pre: cover property (lo_e.done && lo_e.pre);
  c_loop_echo: cover property (ctrl_q[`DCUP_CTRL_LOOP] && lo_fwd);
  c_se: cover property (lo_s.lock && lo_s.se);
endmodule

/* File: verification/dcup_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// host line driver and downward-line receiver
module dcup_host_model (
  // line toward the lower receiver
  output logic tx_true,
  output logic tx_inv,
  // line from the lower transmitter
  input wire logic rx_true,
  input wire logic rx_inv
);
  int bit_ns = 500;
  logic single_ended = 1'b0;
  logic [11:0] rx_q[$];
  // pre-start one, twelve bits lsb first, then an idle low/low gap
  // pins change by non-blocking assignment on pclk edges, bit times are whole cycles
  task automatic send(input logic [11:0] ch);
    tx_true <= ~single_ended;
    tx_inv <= 1'b0;
    #(bit_ns);
    for (int i = 0; i < 12; i++)
    begin
      tx_true <= ch[i] & ~single_ended;
      tx_inv <= ~ch[i];
      #(bit_ns);
    end
    tx_true <= 1'b0;
    tx_inv <= 1'b0;
    #(14 * bit_ns);
  endtask
  // frame every character seen coming down, start bit raises the inverted line
  initial
  begin
    tx_true = 1'b0;
    tx_inv = 1'b0;
    forever
    begin
      logic [11:0] f;
      @(posedge rx_inv);
      #(bit_ns / 2);
      for (int i = 0; i < 12; i++)
      begin
        f[i] = rx_true;
        #(bit_ns);
      end
      rx_q.push_back(f);
    end
  end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
// ==========================================
// testbench top
module tb_top
  import dcup_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic lo_t, lo_n, lo_tx_t, lo_tx_n, lo_oe, up_tx_t, up_tx_n, up_oe;
  logic cut = 1'b0;
  logic junk = 1'b0;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [11:0] PRE = {3'b111, 8'h15, 1'b0};
  localparam logic [11:0] STP = {3'b111, 8'h54, 1'b0};
  // ==========================================
  // clock, junk pattern, timeout
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    junk <= ~junk;
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  // loop cable with pull-down, or junk when cut
  wire up_rx_t = cut ? junk : (up_oe & up_tx_t);
  wire up_rx_n = cut ? ~junk : (up_oe & up_tx_n);
  // ==========================================
  // design and far side
  dcup_port dcup_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lower_rx_true_input(lo_t), .lower_rx_inverted_input(lo_n),
    .lower_tx_true(lo_tx_t), .lower_tx_inv(lo_tx_n), .lower_tx_oe(lo_oe),
    .upper_rx_true_input(up_rx_t), .upper_rx_inverted_input(up_rx_n),
    .upper_tx_true(up_tx_t), .upper_tx_inv(up_tx_n), .upper_tx_oe(up_oe));
  dcup_host_model host_i (.tx_true(lo_t), .tx_inv(lo_n), .rx_true(lo_oe & lo_tx_t), .rx_inv(lo_oe & lo_tx_n));
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask
  // manchester data character: start 0, pairs lsb first, parity 0, stops 1
  function automatic logic [11:0] dchar(input logic [3:0] n);
    logic [11:0] c;
    c = 12'hc00;
    for (int i = 0; i < 4; i++)
    begin
      c[1 + 2 * i] = n[i];
      c[2 + 2 * i] = ~n[i];
    end
    return c;
  endfunction
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic e;
    rd(12'h000, d);
    chk(d, 32'h0);
    rd(12'h004, d);
    chk(d, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
    chk({lo_tx_t, lo_tx_n, lo_oe, up_tx_t, up_tx_n, up_oe}, 32'h9);
    $display("test reset done");
  endtask
  task automatic t_diff_link();
    logic [31:0] d;
    host_i.send(PRE);
    host_i.send(PRE);
    host_i.send(dchar(4'ha));
    rd(12'h004, d);
    chk(d & 32'h3cf, 32'h00c);
    rd(12'h008, d);
    chk(d[3:0], 32'ha);
    chk(32'(host_i.rx_q[$]), 32'(dchar(4'ha)));
    chk({lo_tx_t, lo_tx_n, lo_oe}, 32'h1);
    $display("test diff link done");
  endtask
  task automatic t_errors();
    logic [31:0] d, e0;
    wr(12'h004, 32'h30);
    rd(12'h008, e0);
    host_i.send(PRE);
    host_i.send(dchar(4'h0) ^ 12'h012);
    host_i.send(STP);
    rd(12'h004, d);
    chk(d[5:4], 32'h1);
    rd(12'h008, d);
    chk(d[23:8] - e0[23:8], 32'h0101);
    wr(12'h004, 32'h30);
    host_i.send(dchar(4'h3) ^ 12'h200);
    rd(12'h004, d);
    chk(d[5:4], 32'h2);
    host_i.send(PRE ^ 12'h200);
    rd(12'h004, d);
    chk(d[5:4], 32'h3);
    rd(12'h008, d);
    chk(d[15:8] - e0[15:8], 32'h01);
    wr(12'h004, 32'h30);
    rd(12'h004, d);
    chk(d[5:4], 32'h0);
    $display("test errors done");
  endtask
  task automatic t_float_loop();
    logic [31:0] d;
    wr(12'h000, 32'h3);
    repeat (4) @(posedge pclk);
    chk({lo_oe, up_oe}, 32'h0);
    wr(12'h000, 32'h4);
    cut <= 1'b1;
    host_i.send(dchar(4'h5));
    chk(32'(host_i.rx_q[$]), 32'(dchar(4'h5)));
    rd(12'h000, d);
    chk(d, 32'h4);
    cut <= 1'b0;
    wr(12'h000, 32'h0);
    $display("test float and loopback done");
  endtask
  task automatic t_rates();
    logic [31:0] d;
    for (int r = 1; r <= 2; r++)
    begin
      wr(12'h000, 32'h8);
      rd(12'h004, d);
      chk(d & 32'h3cf, 32'h0);
      host_i.bit_ns = 500 << r;
      host_i.single_ended = (r == 2);
      host_i.send(PRE);
      host_i.send(PRE);
      host_i.send(dchar(4'h6));
      rd(12'h004, d);
      chk(d & 32'h3cf, {22'h0, 2'(r), 2'(r), 6'hc | 6'(r == 2)});
      rd(12'h008, d);
      chk(d[3:0], 32'h6);
      chk(32'(host_i.rx_q[$]), 32'(dchar(4'h6)));
    end
    chk(32'(DCUP_R05M), 32'h2);
    $display("test rates done");
  endtask
  // ==========================================
  // verdict
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_diff_link();
    t_errors();
    t_float_loop();
    t_rates();
    report_and_stop();
  end
endmodule
